//--- src/led_fault_status_capture.sv
module led_fault_status_capture (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire led_fault_pkg::ctrl_pins_t ctrl_pins,
    input wire led_fault_pkg::fault_in_t fault_in,
    input wire logic onoff_apply_en,
    output logic serial_out,
    output logic [led_fault_pkg::CH_COUNT-1:0] sink_channel_n,
    output logic overtemp_warning,
    output logic [led_fault_pkg::CH_COUNT-1:0] status_word,
    output logic onoff_overflow
);

    localparam int N = led_fault_pkg::CH_COUNT;

    // ------------------------------------------------------------------
    // Input synchronisers in the system domain
    // ------------------------------------------------------------------

    logic [1:0] disable_sync_r;
    logic [1:0] strobe_sync_r;
    logic [1:0] temp_sync_r;
    logic [N-1:0] open_sync1_r;
    logic [N-1:0] open_sync2_r;
    logic disable_prev_r;
    logic strobe_prev_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            disable_sync_r <= led_fault_pkg::SYNC_ONES;
            strobe_sync_r <= led_fault_pkg::SYNC_ZERO;
            temp_sync_r <= led_fault_pkg::SYNC_ZERO;
            open_sync1_r <= led_fault_pkg::WORD_ZERO;
            open_sync2_r <= led_fault_pkg::WORD_ZERO;
        end else if (clk_en) begin
            disable_sync_r <= {disable_sync_r[0], ctrl_pins.output_disable};
            strobe_sync_r <= {strobe_sync_r[0], ctrl_pins.transfer_strobe};
            temp_sync_r <= {temp_sync_r[0], fault_in.overtemp};
            open_sync1_r <= fault_in.open_below;
            open_sync2_r <= open_sync1_r;
        end
    end

    logic disable_s;
    logic strobe_s;
    logic disable_rise;
    logic strobe_rise;

    assign disable_s = disable_sync_r[1];
    assign strobe_s = strobe_sync_r[1];
    assign disable_rise = disable_s && !disable_prev_r;
    assign strobe_rise = strobe_s && !strobe_prev_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            disable_prev_r <= 1'b1;
            strobe_prev_r <= 1'b0;
        end else if (clk_en) begin
            disable_prev_r <= disable_s;
            strobe_prev_r <= strobe_s;
        end
    end

    // ------------------------------------------------------------------
    // Fault detection and status capture
    // ------------------------------------------------------------------

    logic [N-1:0] onoff_latch_r;
    logic [N-1:0] open_led_flag_r;
    logic overtemp_warning_r;
    logic [N-1:0] status_word_r;

    // Forces all bits high while the warning stands, else passes the open flags.
    function automatic logic [N-1:0] status_of(input logic [N-1:0] flags, input logic warn);
        status_of = warn ? led_fault_pkg::WORD_ALL_ONES : flags;
    endfunction

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            open_led_flag_r <= led_fault_pkg::WORD_ZERO;
        end else if (clk_en) begin
            if (!disable_s) begin
                // A channel that is off or connected reads zero.
                open_led_flag_r <= onoff_latch_r & open_sync2_r;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            overtemp_warning_r <= 1'b0;
        end else if (clk_en) begin
            overtemp_warning_r <= temp_sync_r[1];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_word_r <= led_fault_pkg::WORD_ZERO;
        end else if (clk_en) begin
            if (disable_rise) begin
                status_word_r <= status_of(open_led_flag_r, overtemp_warning_r);
            end
        end
    end

    // ------------------------------------------------------------------
    // Status word hand-over to the shift clock domain
    // ------------------------------------------------------------------

    logic [N-1:0] load_word_r;
    logic load_toggle_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_word_r <= led_fault_pkg::WORD_ZERO;
            load_toggle_r <= 1'b0;
        end else if (clk_en) begin
            if (strobe_rise) begin
                load_word_r <= status_word_r;
                load_toggle_r <= !load_toggle_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shift register on the link clock
    // ------------------------------------------------------------------

    logic [1:0] lk_load_sync_r;
    logic [1:0] lk_en_sync_r;
    logic lk_load_seen_r;
    logic [N-1:0] shift_reg_r;
    logic serial_out_r;
    logic lk_load_pend;
    logic lk_en;

    assign lk_load_pend = lk_load_sync_r[1] != lk_load_seen_r;
    assign lk_en = lk_en_sync_r[1];

    always_ff @(posedge shift_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_load_sync_r <= led_fault_pkg::SYNC_ZERO;
            lk_en_sync_r <= led_fault_pkg::SYNC_ZERO;
        end else begin
            lk_load_sync_r <= {lk_load_sync_r[0], load_toggle_r};
            lk_en_sync_r <= {lk_en_sync_r[0], clk_en};
        end
    end

    always_ff @(posedge shift_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_load_seen_r <= 1'b0;
            shift_reg_r <= led_fault_pkg::WORD_ZERO;
            serial_out_r <= 1'b0;
        end else if (lk_en) begin
            if (lk_load_pend) begin
                // The status word replaces the on/off data and starts leaving at once.
                lk_load_seen_r <= lk_load_sync_r[1];
                shift_reg_r <= {load_word_r[N-2:0], serial_in};
                serial_out_r <= load_word_r[led_fault_pkg::MSB_POS];
            end else begin
                shift_reg_r <= {shift_reg_r[N-2:0], serial_in};
                serial_out_r <= shift_reg_r[led_fault_pkg::MSB_POS];
            end
        end
    end

    // ------------------------------------------------------------------
    // On/off data into the control latch
    // ------------------------------------------------------------------

    // The shift clock is still while the strobe is handled, so the word is stable.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [N-1:0] fifo_out_data;
    logic fifo_pop;
    logic onoff_overflow_r;

    assign fifo_pop = fifo_out_valid && onoff_apply_en;

    onoff_fifo #(
        .WIDTH(N),
        .DEPTH(led_fault_pkg::ONOFF_FIFO_DEPTH)
    ) u_onoff_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_data(shift_reg_r),
        .in_valid(strobe_rise),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(onoff_apply_en)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            onoff_latch_r <= led_fault_pkg::WORD_ZERO;
        end else if (clk_en) begin
            if (fifo_pop) begin
                onoff_latch_r <= fifo_out_data;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            onoff_overflow_r <= 1'b0;
        end else if (clk_en) begin
            if (strobe_rise && !fifo_in_ready) begin
                onoff_overflow_r <= 1'b1;
            end else if (strobe_rise) begin
                onoff_overflow_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel drive and outputs
    // ------------------------------------------------------------------

    logic [N-1:0] sink_channel_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sink_channel_r <= led_fault_pkg::WORD_ZERO;
        end else if (clk_en) begin
            // The warning is deliberately left out of this gate.
            sink_channel_r <= disable_s ? led_fault_pkg::WORD_ZERO : onoff_latch_r;
        end
    end

    assign serial_out = serial_out_r;
    assign sink_channel_n = sink_channel_r;
    assign overtemp_warning = overtemp_warning_r;
    assign status_word = status_word_r;
    assign onoff_overflow = onoff_overflow_r;

endmodule

//--- common/led_fault_pkg.sv
// What this block does
// - While output disable is low, a channel that is on and whose output sits below the open-detect threshold gets its open flag set.
// - The over-temperature warning bit stays one for as long as the temperature comparator reports over-temperature.
// - Once over-temperature clears, each status bit again shows only its own channel's open result.
// - An over-temperature warning never switches a channel off.
// - A rising edge of output disable captures the results into the status latch, which then holds until the next rising edge of output disable.
// - A rising edge of the transfer strobe loads the status latch into the 16-bit shift register, discarding the on/off data there.
// - After that load the status bits leave on the serial output one per rising shift clock edge.
// - While the warning is active every bit of the captured status word is one.
// - Without a warning, a status bit is zero for a connected LED and one only for a channel that is on and faulted.
// - The status shift register holds exactly one bit for each of the sixteen channels.
// - All channel outputs are off while output disable is high, whatever the on/off latch holds.
// - Each rising shift clock edge moves serial input into the least significant bit and changes the serial output.
// - A rising edge of the transfer strobe pushes the shift register into an eight-word queue that feeds the on/off latch while onoff_apply_en is high.
package led_fault_pkg;

    localparam int CH_COUNT = 16;
    localparam int MSB_POS = CH_COUNT - 1;
    localparam int ONOFF_FIFO_DEPTH = 8;

    localparam logic [CH_COUNT-1:0] WORD_ZERO = 16'h0000;
    localparam logic [CH_COUNT-1:0] WORD_ALL_ONES = 16'hffff;
    localparam logic [1:0] SYNC_ZERO = 2'h0;
    localparam logic [1:0] SYNC_ONES = 2'h3;

    // Comparator levels seen at the analog edge of the block.
    typedef struct packed {
        logic [CH_COUNT-1:0] open_below;
        logic overtemp;
    } fault_in_t;

    // Pins driven by the external controller, sampled in the system domain.
    typedef struct packed {
        logic output_disable;
        logic transfer_strobe;
    } ctrl_pins_t;

endpackage

//--- src/onoff_fifo.sv
module onoff_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] rd_idx_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_idx_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] idx);
        next_idx = (idx == LAST_IDX) ? '0 : idx + AW'(1);
    endfunction

    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem_r[wr_idx_r] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_idx_r <= next_idx(wr_idx_r);
            end
            if (pop) begin
                rd_idx_r <= next_idx(rd_idx_r);
            end
            if (push && !pop) begin
                count_r <= count_r + CW'(1);
            end else if (pop && !push) begin
                count_r <= count_r - CW'(1);
            end
        end
    end

endmodule

//--- verification/led_fault_status_capture_chk.sv
// ----------------------------------------
// Concurrent checks on the capture block.
// ----------------------------------------
module led_fault_status_capture_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire led_fault_pkg::ctrl_pins_t ctrl_pins,
    input wire led_fault_pkg::fault_in_t fault_in,
    input wire logic [led_fault_pkg::CH_COUNT-1:0] sink_channel_n,
    input wire logic overtemp_warning,
    input wire logic [led_fault_pkg::CH_COUNT-1:0] status_word
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic dis = ctrl_pins.output_disable;
    wire logic hot = fault_in.overtemp;
    default clocking cb @(posedge clk);
    endclocking
    // Checks pause while the clock enable holds the block frozen.
    default disable iff (sys_rst || !clk_en);
    sequence s_cool_on;
        !dis && !hot && $stable(fault_in.open_below) && $stable(sink_channel_n);
    endsequence
    sequence s_hot_on;
        !dis && hot;
    endsequence
    property p_off_dis; dis [*4] |-> sink_channel_n == '0; endproperty
    a_off_dis: assert property (p_off_dis) else $error("channel on while disabled");
    property p_rise_off; $rose(dis) |-> ##[1:4] sink_channel_n == '0; endproperty
    a_rise_off: assert property (p_rise_off) else $error("outputs not cut");
    property p_hold_hi; dis [*6] |-> $stable(status_word); endproperty
    a_hold_hi: assert property (p_hold_hi) else $error("status moved while held");
    property p_hold_lo; !dis [*5] |-> $stable(status_word); endproperty
    a_hold_lo: assert property (p_hold_lo) else $error("status moved without capture");
    property p_hot_cap; s_hot_on [*4] ##1 (dis && hot) [*5]
        |-> status_word == led_fault_pkg::WORD_ALL_ONES; endproperty
    a_hot_cap: assert property (p_hot_cap) else $error("warning not forced into status");
    property p_cold_cap; s_cool_on [*6] ##1 (dis && !hot && $stable(fault_in.open_below)) [*5]
        |-> status_word == ($past(sink_channel_n, 5) & fault_in.open_below); endproperty
    a_cold_cap: assert property (p_cold_cap) else $error("open flags wrong");
    property p_warn; $stable(hot) [*5] |-> overtemp_warning == hot; endproperty
    a_warn: assert property (p_warn) else $error("warning does not follow sensor");
    property p_no_gate; (!dis && !ctrl_pins.transfer_strobe) [*6] ##0 $rose(overtemp_warning)
        |-> $stable(sink_channel_n) [*3]; endproperty
    a_no_gate: assert property (p_no_gate) else $error("warning changed outputs");
endmodule

bind led_fault_status_capture led_fault_status_capture_chk u_chk (
    .clk, .sys_rst, .clk_en, .ctrl_pins, .fault_in, .sink_channel_n, .overtemp_warning,
    .status_word
);

//--- verification/led_ctrl_model.sv
module led_ctrl_model (
    output logic shift_clk,
    output logic serial_in,
    input wire logic serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        shift_clk = 1'b0;
        serial_in = 1'b0;
    end
    // ----------------------------------------
    // Frame of two lead-in edges and sixteen data edges.
    // ----------------------------------------
    task automatic frame(input logic [15:0] d, output logic [15:0] q);
        #13;
        for (int i = 0; i < 18; i++) begin
            serial_in = i < 2 ? ~serial_in : d[17 - i];
            #40 shift_clk = 1'b1;
            #1 if (i > 1) q[17 - i] = serial_out;
            #39 shift_clk = 1'b0;
        end
        serial_in = ~serial_in;
    endtask
endmodule

//--- verification/led_fault_status_capture_tb.sv
module led_fault_status_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, clk_en, onoff_apply_en, shift_clk, serial_in, serial_out;
    logic onoff_overflow, overtemp_warning, ovf_m, load_ok, stat_ok;
    logic [15:0] sink_channel_n, status_word, latch_m, status_m, load_m, q0;
    logic [15:0] words_m[$];
    logic [31:0] seed = 32'h00015de2;
    led_fault_pkg::ctrl_pins_t pins;
    led_fault_pkg::fault_in_t flt;
    int err_total, check_count, cycles;

    led_fault_status_capture u_led_fault_status_capture (
        .clk, .sys_rst, .clk_en, .shift_clk, .serial_in, .ctrl_pins(pins),
        .fault_in(flt), .onoff_apply_en, .serial_out, .sink_channel_n,
        .overtemp_warning, .status_word, .onoff_overflow
    );
    led_ctrl_model u_led_ctrl_model (.shift_clk, .serial_in, .serial_out);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // Write a word, strobe it, and read back the status it displaced.
    // ----------------------------------------
    task automatic xfer(input logic [15:0] d);
        logic [15:0] q;
        u_led_ctrl_model.frame(d, q);
        if (load_ok) check(q, load_m);
        tick(4);
        pins.transfer_strobe = 1'b1;
        tick(4);
        pins.transfer_strobe = 1'b0;
        tick(4);
        load_m = status_m;
        load_ok = stat_ok;
        ovf_m = words_m.size() > 7;
        if (!ovf_m) words_m.push_back(d);
        if (onoff_apply_en) begin
            latch_m = words_m[$];
            words_m.delete();
        end
    endtask

    task automatic capture(input logic [15:0] ob, input logic ot);
        pins.output_disable = 1'b0;
        tick(8);
        flt.open_below = ob;
        flt.overtemp = ot;
        tick(25);
        check(sink_channel_n, latch_m);
        pins.output_disable = 1'b1;
        tick(6);
        status_m = ot ? 16'hffff : latch_m & ob;
        stat_ok = 1'b1;
        check(sink_channel_n, 16'h0000);
        check(status_word, status_m);
        check({15'h0000, overtemp_warning}, {15'h0000, ot});
        flt.open_below = ~ob;
        tick(4);
        check(status_word, status_m);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        sys_rst = 1'b1;
        onoff_apply_en = 1'b1;
        clk_en = 1'b1;
        pins = 2'h2;
        flt = '0;
        {ovf_m, load_ok, stat_ok} = 3'h0;
        latch_m = 16'h0000;
        fork
            u_led_ctrl_model.frame(16'h0000, q0);
        join_none
        tick(9);
        check(status_word | sink_channel_n, 16'h0000);
        check({13'h0000, serial_out, onoff_overflow, overtemp_warning}, 16'h0000);
        tick(1);
        sys_rst = 1'b0;
        wait fork;
        for (int k = 0; k < 6; k++) begin
            xfer(rnd());
            capture(rnd(), k % 3 == 1);
        end
        // The on/off side stalls so the queue fills until a word is refused.
        pins.output_disable = 1'b0;
        onoff_apply_en = 1'b0;
        for (int k = 0; k < 9; k++) xfer(rnd());
        check({15'h0000, onoff_overflow}, {15'h0000, ovf_m});
        check(sink_channel_n, latch_m);
        onoff_apply_en = 1'b1;
        tick(12);
        latch_m = words_m[$];
        words_m.delete();
        check(sink_channel_n, latch_m);
        xfer(rnd());
        tick(2);
        check({15'h0000, onoff_overflow}, {15'h0000, ovf_m});
        check(sink_channel_n, latch_m);
        tick(20);
        // A frozen block ignores the disable pin until the enable returns.
        clk_en = 1'b0;
        pins.output_disable = 1'b1;
        tick(6);
        check(sink_channel_n, latch_m);
        check(status_word, status_m);
        clk_en = 1'b1;
        tick(6);
        check(sink_channel_n, 16'h0000);
        check(status_word, latch_m & flt.open_below);
        wrap_up();
    end
endmodule
